// ==== hw/damr_top.sv ====
// Purpose: dram address multiplexer with refresh address counter
// Assumes: 20 MHz CLK_I, RST_I synchronous active high, async pins
// Notes:   two cycle pin sync, outputs registered, one extra cycle
`timescale 1ns/100ps
module damr_top (
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  input  wire logic [10:0] ROW_ADDR_IN_I,
  input  wire logic [10:0] COL_ADDR_IN_I,
  input  wire logic        REFRESH_SELECT_N_I,
  input  wire logic        ROW_COL_SELECT_I,
  input  wire logic        REFRESH_STEP_I,
  input  wire logic        COUNTER_CLEAR_I,
  output logic      [10:0] MEM_ADDR_OUT_N_O
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [25:0] sync1_q;
  logic [25:0] sync2_q;
  logic        step_old_q;
  logic [10:0] addr_q;
  logic [10:0] addr_d;

  wire  [25:0] pins_in = {ROW_ADDR_IN_I, COL_ADDR_IN_I, REFRESH_SELECT_N_I,
                          ROW_COL_SELECT_I, REFRESH_STEP_I, COUNTER_CLEAR_I};
  wire  [10:0] row_s   = sync2_q[25:15];
  wire  [10:0] col_s   = sync2_q[14:4];
  wire         ref_n_s = sync2_q[3];
  wire         rc_s    = sync2_q[2];
  wire         step_s  = sync2_q[1];
  wire         clr_s   = sync2_q[0];

  // two flops per pin
  // reset to idle pin levels, so the edge detector sees no false rise
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      sync1_q <= damr_pkg::SYNC_RESET;
      sync2_q <= damr_pkg::SYNC_RESET;
    end else begin
      sync1_q <= pins_in;
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------
  // refresh counter
  // ----------------------------------------
  damr_cnt_if cnt_bus ();

  assign cnt_bus.step  = step_s && !step_old_q;
  assign cnt_bus.clear = clr_s;

  // step edge history
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      step_old_q <= damr_pkg::STEP_IDLE;
    end else begin
      step_old_q <= step_s;
    end
  end

  damr_counter u_counter (
    .clk_i (CLK_I),
    .rst_i (RST_I),
    .cnt   (cnt_bus.cnt)
  );

  // ----------------------------------------
  // address selection
  // ----------------------------------------
  damr_pkg::damr_src_t src;

  assign src = (ref_n_s == damr_pkg::REF_ACT_LVL) ? damr_pkg::DAMR_SRC_REF
             : (rc_s == damr_pkg::ROW_SEL_LVL)    ? damr_pkg::DAMR_SRC_ROW
             : damr_pkg::DAMR_SRC_COL;

  assign addr_d = (src == damr_pkg::DAMR_SRC_REF) ? ~cnt_bus.value
                : (src == damr_pkg::DAMR_SRC_ROW) ? ~row_s
                : ~col_s;

  // output register, idle row zero gives all ones
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      addr_q <= damr_pkg::OUT_RESET;
    end else begin
      addr_q <= addr_d;
    end
  end

  assign MEM_ADDR_OUT_N_O = addr_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_ref_out;
    @(posedge CLK_I) disable iff (RST_I)
      (!ref_n_s) |=> (MEM_ADDR_OUT_N_O == ~$past(cnt_bus.value));
  endproperty
  a_ref_out: assert property (p_ref_out)
    else $error("refresh address not on outputs");

  property p_row_out;
    @(posedge CLK_I) disable iff (RST_I)
      (ref_n_s && !rc_s) |=> (MEM_ADDR_OUT_N_O == ~$past(row_s));
  endproperty
  a_row_out: assert property (p_row_out)
    else $error("row address not on outputs");

  property p_col_out;
    @(posedge CLK_I) disable iff (RST_I)
      (ref_n_s && rc_s) |=> (MEM_ADDR_OUT_N_O == ~$past(col_s));
  endproperty
  a_col_out: assert property (p_col_out)
    else $error("column address not on outputs");

  property p_rc_ignored;
    @(posedge CLK_I) disable iff (RST_I)
      (!ref_n_s && !$past(ref_n_s) && $stable(cnt_bus.value)
       && $changed(rc_s))
        |=> $stable(MEM_ADDR_OUT_N_O);
  endproperty
  a_rc_ignored: assert property (p_rc_ignored)
    else $error("row/column select moved refresh output");

  property p_edge_counts;
    @(posedge CLK_I) disable iff (RST_I)
      (step_s && !step_old_q && !clr_s)
        |=> (cnt_bus.value == 11'($past(cnt_bus.value) + 11'h001));
  endproperty
  a_edge_counts: assert property (p_edge_counts)
    else $error("step edge did not count");

  // ----------------------------------------
  // further checks
  // ----------------------------------------
  // idle outputs during reset
  property p_out_reset;
    @(posedge CLK_I)
      RST_I |=> (MEM_ADDR_OUT_N_O == damr_pkg::OUT_RESET);
  endproperty
  a_out_reset: assert property (p_out_reset)
    else $error("outputs not idle after reset");

  property p_clear_ref_out;
    @(posedge CLK_I) disable iff (RST_I)
      (clr_s && !ref_n_s) ##1 (!ref_n_s)
        |=> (MEM_ADDR_OUT_N_O == ~damr_pkg::CNT_RESET);
  endproperty
  a_clear_ref_out: assert property (p_clear_ref_out)
    else $error("cleared count not on outputs");

  property p_clear_held;
    @(posedge CLK_I) disable iff (RST_I)
      (clr_s && $past(clr_s)) |-> (cnt_bus.value == damr_pkg::CNT_RESET);
  endproperty
  a_clear_held: assert property (p_clear_held)
    else $error("counter not held at zero");

  property p_count_cause;
    @(posedge CLK_I) disable iff (RST_I)
      $changed(cnt_bus.value) |-> ($past(cnt_bus.step) || $past(cnt_bus.clear));
  endproperty
  a_count_cause: assert property (p_count_cause)
    else $error("counter changed without step or clear");

  property p_wrap_top;
    @(posedge CLK_I) disable iff (RST_I)
      (cnt_bus.step && !cnt_bus.clear
       && cnt_bus.value == damr_pkg::CNT_ALL_ONE)
        |=> (cnt_bus.value == damr_pkg::CNT_RESET);
  endproperty
  a_wrap_top: assert property (p_wrap_top)
    else $error("counter did not wrap to zero");

  property p_ref_holds;
    @(posedge CLK_I) disable iff (RST_I)
      (!ref_n_s && !$past(ref_n_s) && $stable(cnt_bus.value))
        |=> $stable(MEM_ADDR_OUT_N_O);
  endproperty
  a_ref_holds: assert property (p_ref_holds)
    else $error("refresh output moved with steady count");

  property p_row_holds;
    @(posedge CLK_I) disable iff (RST_I)
      (ref_n_s && !rc_s && $past(ref_n_s) && !$past(rc_s) && $stable(row_s))
        |=> $stable(MEM_ADDR_OUT_N_O);
  endproperty
  a_row_holds: assert property (p_row_holds)
    else $error("row output moved with steady row");

  property p_col_holds;
    @(posedge CLK_I) disable iff (RST_I)
      (ref_n_s && rc_s && $past(ref_n_s) && $past(rc_s) && $stable(col_s))
        |=> $stable(MEM_ADDR_OUT_N_O);
  endproperty
  a_col_holds: assert property (p_col_holds)
    else $error("column output moved with steady column");
endmodule : damr_top

// ==== hw/damr_pkg.sv ====
// Purpose: shared constants for the dram address mux with refresh counter
// Assumes: one 20 MHz clock, synchronous active high reset
// Notes:   widths, select encodings, counter constants and reset levels
package damr_pkg;
  localparam int unsigned ADDR_W      = 11;
  localparam logic [10:0] CNT_RESET   = 11'h000;
  localparam logic [10:0] CNT_STEP    = 11'h001;
  localparam logic [10:0] CNT_ALL_ONE = 11'h7FF;
  localparam logic        ROW_SEL_LVL = 1'b0;
  localparam logic        REF_ACT_LVL = 1'b0;
  // reset levels: select negated and step high, so no false step edge
  localparam logic [25:0] SYNC_RESET  = 26'h000000A;
  localparam logic        STEP_IDLE   = 1'b1;
  localparam logic [10:0] OUT_RESET   = 11'h7FF;

  typedef enum logic [1:0] {
    DAMR_SRC_ROW = 2'b00,
    DAMR_SRC_COL = 2'b01,
    DAMR_SRC_REF = 2'b11
  } damr_src_t;
endpackage : damr_pkg

// ==== hw/damr_cnt_if.sv ====
// Purpose: carries the refresh counter controls and value
// Assumes: all signals on CLK_I of the top module
// Notes:   step is a one-cycle rising edge pulse
`timescale 1ns/100ps
interface damr_cnt_if;
  logic        step;
  logic        clear;
  logic [10:0] value;
  modport ctl (output step, output clear, input value);
  modport cnt (input step, input clear, output value);
endinterface : damr_cnt_if

// ==== hw/damr_counter.sv ====
// Purpose: eleven bit refresh counter
// Assumes: step and clear are synchronous to clk_i
// Notes:   clear beats step; wraps from all ones to zero
`timescale 1ns/100ps
module damr_counter (
  input  wire logic clk_i,
  input  wire logic rst_i,
  damr_cnt_if.cnt   cnt
);
  logic [10:0] cnt_q;
  logic [10:0] cnt_d;

  // ----------------------------------------
  // next value
  // ----------------------------------------
  // clear over step
  // add one per step; natural wrap
  assign cnt_d = cnt.clear ? damr_pkg::CNT_RESET
               : cnt.step  ? 11'(cnt_q + damr_pkg::CNT_STEP)
               : cnt_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= damr_pkg::CNT_RESET;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign cnt.value = cnt_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_step_adds;
    @(posedge clk_i) disable iff (rst_i)
      (cnt.step && !cnt.clear) |=> (cnt_q == 11'($past(cnt_q) + 11'h001));
  endproperty
  a_step_adds: assert property (p_step_adds)
    else $error("counter did not advance on step");

  property p_clear_zero;
    @(posedge clk_i) disable iff (rst_i)
      cnt.clear |=> (cnt_q == 11'h000);
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("counter not zero after clear");

  property p_clear_wins;
    @(posedge clk_i) disable iff (rst_i)
      (cnt.clear && cnt.step) |=> (cnt_q == 11'h000);
  endproperty
  a_clear_wins: assert property (p_clear_wins)
    else $error("step beat clear");

  property p_wrap;
    @(posedge clk_i) disable iff (rst_i)
      (cnt.step && !cnt.clear && cnt_q == 11'h7FF) |=> (cnt_q == 11'h000);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("counter did not wrap");

  property p_hold;
    @(posedge clk_i) disable iff (rst_i)
      (!cnt.step && !cnt.clear) |=> $stable(cnt_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("counter moved without cause");
endmodule : damr_counter

// ==== sim/damr_ctl_model.sv ====
// Purpose: dram timing controller model driving the mux inputs
// Assumes: levels change 2 ns after a CLK_I rising edge, then hold
// Notes:   the step pin follows refresh select, as the controller ties it
`timescale 1ns/100ps
module damr_ctl_model (
  input  wire logic        CLK_I,
  output logic      [10:0] ROW_O,
  output logic      [10:0] COL_O,
  output logic             REF_N_O,
  output logic             RC_O,
  output logic             STEP_O,
  output logic             CLR_O
);
  assign STEP_O = REF_N_O;

  // idle levels from time zero
  initial begin
    ROW_O   = 11'h000;
    COL_O   = 11'h000;
    REF_N_O = 1'b1;
    RC_O    = 1'b0;
    CLR_O   = 1'b0;
  end

  // clear level on request
  // one new set of levels just after an edge, held until the next call
  task automatic drive(input logic [10:0] r, input logic [10:0] c,
                       input logic rf, input logic rc, input logic cl);
    @(posedge CLK_I);
    #2;
    ROW_O   = r;
    COL_O   = c;
    REF_N_O = rf;
    RC_O    = rc;
    CLR_O   = cl;
  endtask
endmodule // damr_ctl_model

// ==== sim/testbench.sv ====
// Purpose: self-checking bench for the address mux with refresh counter
// Assumes: outputs settle within six cycles of any pin change
// Notes:   counter steps by toggling refresh select low then high
`timescale 1ns/100ps
module testbench;
  logic        CLK_I;
  logic        RST_I;
  logic [10:0] row, col, ma;
  logic        rf, rc, st, cl;
  int          n_mismatch = 0;
  int          checked    = 0;

  // 20 MHz clock
  initial begin
    CLK_I = 1'b0;
    forever #25 CLK_I = ~CLK_I;
  end

  damr_ctl_model i_damr_ctl_model (.CLK_I(CLK_I), .ROW_O(row),
    .COL_O(col), .REF_N_O(rf), .RC_O(rc), .STEP_O(st), .CLR_O(cl));
  damr_top i_damr_top (.CLK_I(CLK_I), .RST_I(RST_I), .ROW_ADDR_IN_I(row),
    .COL_ADDR_IN_I(col), .REFRESH_SELECT_N_I(rf), .ROW_COL_SELECT_I(rc),
    .REFRESH_STEP_I(st), .COUNTER_CLEAR_I(cl), .MEM_ADDR_OUT_N_O(ma));

  // compare the address outputs
  task automatic chk(input logic [10:0] exp, input string what);
    checked++;
    if (ma !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t %s got %h exp %h", $time, what, ma, exp);
    end
  endtask

  // apply levels, let the pipeline settle, compare
  task automatic go(input logic [10:0] r, input logic [10:0] c,
                    input logic f, input logic s, input logic k,
                    input logic [10:0] exp, input string what);
    i_damr_ctl_model.drive(r, c, f, s, k);
    repeat (6) @(posedge CLK_I);
    #2;
    chk(exp, what);
  endtask

  task automatic t_mux();
    go(11'h555, 11'h2AA, 1'b1, 1'b0, 1'b0, 11'h2AA, "row");
    go(11'h555, 11'h2AA, 1'b1, 1'b1, 1'b0, 11'h555, "col");
    for (int i = 0; i < 11; i++) begin
      go(11'h001 << i, ~(11'h001 << i), 1'b1, 1'b0, 1'b0,
         ~(11'h001 << i), "row bit");
    end
    $display("test mux done");
  endtask

  task automatic t_refresh();
    go(11'h7FF, 11'h000, 1'b0, 1'b0, 1'b0, 11'h7FF, "count zero");
    go(11'h7FF, 11'h000, 1'b1, 1'b0, 1'b0, 11'h000, "row");
    go(11'h7FF, 11'h000, 1'b0, 1'b1, 1'b0, 11'h7FE, "count one");
    go(11'h7FF, 11'h000, 1'b0, 1'b0, 1'b0, 11'h7FE, "one row");
    $display("test refresh done");
  endtask

  task automatic t_clear();
    go(11'h7FF, 11'h000, 1'b1, 1'b0, 1'b1, 11'h000, "row clr");
    go(11'h7FF, 11'h000, 1'b0, 1'b0, 1'b1, 11'h7FF, "held");
    go(11'h7FF, 11'h000, 1'b1, 1'b0, 1'b1, 11'h000, "step clr");
    go(11'h7FF, 11'h000, 1'b0, 1'b0, 1'b0, 11'h7FF, "cleared");
    $display("test clear done");
  endtask

  task automatic t_wrap();
    logic [10:0] n;
    for (int i = 1; i <= 2048; i++) begin
      n = i[10:0];
      go(11'h000, 11'h000, 1'b1, 1'b0, 1'b0, 11'h7FF, "idle");
      go(11'h000, 11'h000, 1'b0, 1'b0, 1'b0, ~n, "count");
    end
    $display("test wrap done");
  endtask

  task automatic end_of_test();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // watchdog: the tests need about 30000 cycles
  initial begin
    repeat (60000) @(posedge CLK_I);
    n_mismatch++;
    $display("mismatch t=%0t watchdog expired", $time);
    end_of_test();
  end

  // main sequence
  initial begin
    RST_I = 1'b1;
    repeat (12) @(posedge CLK_I);
    #2;
    RST_I = 1'b0;
    chk(11'h7FF, "reset value");
    t_mux();
    t_refresh();
    t_clear();
    t_wrap();
    end_of_test();
  end
endmodule // testbench
